// ---- rtl/pmr_pkg.sv ----
// Purpose: Constants shared by the main control and status register group.
// Assumes: 25 MHz clock, 16-bit register words, 6-bit register addresses.
// Notes: Data bit n of a register word is frame bit n.
package pmr_pkg;
    // --------------------------------------------------------------------
    // Register addresses and reset values
    // --------------------------------------------------------------------
    localparam logic [5:0] ADR_MAIN_EVENT_FLAGS = 6'h00;
    localparam logic [5:0] ADR_MAIN_MODE_CONTROL = 6'h01;
    localparam logic [5:0] ADR_STATE_MACHINE_CONTROL = 6'h02;
    localparam logic [5:0] ADR_REGULATOR_ONOFF_REQUESTS = 6'h03;
    localparam logic [15:0] RST_MAIN_MODE_CONTROL = 16'h0000;
    localparam logic [3:0] RST_STANDBY_TIMER_WINDOW = 4'h0;
    // --------------------------------------------------------------------
    // Field positions
    // --------------------------------------------------------------------
    localparam int MODE_TEST_ON = 0;
    localparam int MODE_WAKE_A_DIS = 1;
    localparam int MODE_WAKE_B_DIS = 2;
    localparam int MODE_TEST_LEVEL = 3;
    localparam int MODE_SLP_ON = 4;
    localparam int MODE_MAIN_NORMAL = 5;
    localparam int MODE_EXT_CLK_DIS = 6;
    localparam int MODE_PLL_LOCKED = 7;
    localparam int SMC_ENTER_OFF = 0;
    localparam int SMC_TIMER_ON = 10;
    localparam int SMC_WINDOW_LSB = 12;
    localparam int REQ_OFF_LSB = 8;
    localparam int DEV_FS_SEL = 1;
    // --------------------------------------------------------------------
    // CRC and timing
    // --------------------------------------------------------------------
    localparam logic [7:0] CRC_POLY = 8'h1D;
    localparam logic [7:0] CRC_SEED = 8'hFF;
    localparam int CLK_PERIOD_NS = 40;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [23:0] WINDOW_MS [16] = '{
        24'd16, 24'd32, 24'd128, 24'd512, 24'd1024, 24'd4096, 24'd8192,
        24'd16384, 24'd65536, 24'd131072, 24'd262144, 24'd524288,
        24'd1048576, 24'd2097152, 24'd4194304, 24'd8388608};
endpackage

// ---- rtl/pmr_crc8.sv ----
// Purpose: Combinational 8-bit CRC over a 32-bit frame, MSB first.
// Assumes: Polynomial and seed from the package.
// Notes: Used both to check writes and to sign read answers.
`timescale 1ns/1ns
`default_nettype none
module pmr_crc8
    import pmr_pkg::*;
(
    input wire logic [31:0] frame,
    output logic [7:0] crc
);
    always_comb
    begin
        logic [7:0] c;
        logic fb;
        c = CRC_SEED;
        fb = 1'b0;
        for (int i = 31; i >= 0; i--)
        begin
            fb = c[7] ^ frame[i];
            c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        crc = c;
    end
endmodule
`default_nettype wire

// ---- rtl/pmr_regs.sv ----
// Purpose: Main-logic control and status registers of the power manager.
// Assumes: A serial front end hands over whole decoded frames.
// Notes: Event flags are sticky until power-on reset.
//
// Functional notes
// RULE1 - Communication error sets the comm error flag.
// RULE2 - A wake on either wake input sets the wake event flag.
// RULE3 - One sticky flag per regulator, set on status change or failure.
// RULE4 - Die temperature event sets the die temperature flag.
// RULE5 - Bias supply upper undervoltage sets the bias supply flag.
// RULE6 - Any of three battery undervoltages sets one battery flag.
// RULE7 - Standby timer expiry sets the standby timer flag.
// RULE8 - Thermal shutdown sets its flag; flags clear only at reset.
// RULE9 - Test enable bit turns the power-good test on, if fused.
// RULE10 - Under test, power-good output is high for level 0, low for 1.
// RULE11 - Each wake input has its own disable bit; 1 blocks waking.
// RULE12 - Fused and enabled, a second wake input request enters deep sleep.
// RULE13 - Read-only bit shows main state machine in normal mode.
// RULE14 - External clock disable bit blocks external clock selection.
// RULE15 - Read-only bit shows PLL lock.
// RULE16 - Writing one to enter-off moves the device to off.
// RULE17 - Standby timer runs only when enabled; enable resets from fuse.
// RULE18 - Four-bit window code selects timer duration in milliseconds.
// RULE19 - Writing one to an enable request switches that regulator on.
// RULE20 - Writing one to a disable request switches that regulator off.
// RULE21 - Pre-regulator disable request is accepted for dual systems.
// RULE22 - Host addresses this group with the selector bit at zero.
// RULE23 - Every access carries an 8-bit CRC over address and data.
// RULE24 - Disable wins when enable and disable arrive together.
// RULE25 - Request and enter-off bits are strobes reading back as zero.
`timescale 1ns/1ns
`default_nettype none
module pmr_regs
    import pmr_pkg::*;
#(
    parameter int MS_CYCLES_P = MS_CYCLES
)
(
    input wire logic clk,
    input wire logic rst,
    input wire logic acc_valid,
    input wire logic acc_write,
    input wire logic [7:0] acc_dev_byte,
    input wire logic [7:0] acc_reg_byte,
    input wire logic [15:0] acc_wdata,
    input wire logic [7:0] acc_crc,
    input wire logic acc_proto_err,
    output logic rd_valid,
    output logic [15:0] rd_data,
    output logic [7:0] rd_crc,
    input wire logic ev_die_temp,
    input wire logic ev_bias_uvh,
    input wire logic wake_input_a,
    input wire logic wake_input_b,
    input wire logic [7:0] ev_regulator,
    input wire logic ev_hv_linreg,
    input wire logic ev_batt_uvl,
    input wire logic ev_batt_uvh,
    input wire logic ev_batt_uv7,
    input wire logic ev_thermal_shutdown,
    input wire logic pgood_test_fuse,
    input wire logic deep_sleep_fuse,
    input wire logic standby_timer_fuse,
    input wire logic sleep_power_good_in,
    input wire logic main_normal,
    input wire logic pll_locked,
    input wire logic ext_freq_input_req,
    output logic sleep_power_good_out,
    output logic wake_accepted,
    output logic deep_sleep_state,
    output logic ext_freq_input,
    output logic enter_off_state,
    output logic [7:0] reg_off_req,
    output logic [6:0] reg_on_req
);
    // --------------------------------------------------------------------
    // Frame decode and CRC check
    // --------------------------------------------------------------------
    logic [15:0] flags_q, flags_d;
    logic [7:0] mode_q;
    logic [3:0] window_q;
    logic timer_on_q, init_done_q, rd_valid_q;
    logic [15:0] rd_data_q;
    logic [7:0] rd_crc_q;
    logic pgood_q, wake_q, slp_q, ext_q, off_q;
    logic [7:0] off_req_q;
    logic [6:0] on_req_q;
    logic [19:0] pre_q;
    logic [23:0] ms_q;
    logic [7:0] wr_crc, ans_crc;
    logic [15:0] rdata_next;
    wire main_sel = ~acc_dev_byte[DEV_FS_SEL] & (acc_reg_byte[7:6] == 2'b00);
    wire [5:0] adr = acc_reg_byte[5:0];
    wire crc_ok = (wr_crc == acc_crc);
    wire wr_any = acc_valid & acc_write & main_sel;
    wire wr_ok = wr_any & crc_ok;
    wire rd_ok = acc_valid & ~acc_write & main_sel;
    wire comm_err = acc_proto_err | (wr_any & ~crc_ok);
    wire wr_mode = wr_ok & (adr == ADR_MAIN_MODE_CONTROL);
    wire wr_smc = wr_ok & (adr == ADR_STATE_MACHINE_CONTROL);
    wire wr_req = wr_ok & (adr == ADR_REGULATOR_ONOFF_REQUESTS);

    // The write check covers device byte, register byte and data. [RULE23]
    pmr_crc8 u_wr_crc (
        .frame({acc_dev_byte, acc_reg_byte, acc_wdata}),
        .crc(wr_crc)
    );
    // The read answer is signed over the same fields with the read data.
    pmr_crc8 u_rd_crc (
        .frame({acc_dev_byte, acc_reg_byte, rdata_next}),
        .crc(ans_crc)
    );

    // --------------------------------------------------------------------
    // Standby timer
    // --------------------------------------------------------------------
    wire ms_tick = (pre_q == MS_CYCLES_P[19:0] - 20'd1);
    wire [23:0] win_ms = WINDOW_MS[window_q]; // [RULE18]
    wire timer_expire = timer_on_q & ms_tick & (ms_q == win_ms - 24'd1);

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pre_q <= 20'd0;
            ms_q <= 24'd0;
        end
        else if (!timer_on_q) // [RULE17]
        begin
            pre_q <= 20'd0;
            ms_q <= 24'd0;
        end
        else
        begin
            pre_q <= ms_tick ? 20'd0 : pre_q + 20'd1;
            if (ms_tick)
                ms_q <= timer_expire ? 24'd0 : ms_q + 24'd1;
        end
    end

    // --------------------------------------------------------------------
    // Sticky event flags
    // --------------------------------------------------------------------
    wire wake_a = wake_input_a & ~mode_q[MODE_WAKE_A_DIS]; // [RULE11]
    wire wake_b = wake_input_b & ~mode_q[MODE_WAKE_B_DIS]; // [RULE11]
    wire [15:0] events = {
        ev_die_temp,                             // [RULE4]
        ev_bias_uvh,                             // [RULE5]
        comm_err,                                // [RULE1]
        wake_a | wake_b,                         // [RULE2]
        ev_regulator,                            // [RULE3]
        ev_hv_linreg,                            // [RULE3]
        timer_expire,                            // [RULE7]
        ev_batt_uvl | ev_batt_uvh | ev_batt_uv7, // [RULE6]
        ev_thermal_shutdown};                    // [RULE8]

    // Flags only ever set; hardware offers no clear path but reset. [RULE8]
    assign flags_d = flags_q | events;

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            flags_q <= 16'h0000;
        else
            flags_q <= flags_d;
    end

    // --------------------------------------------------------------------
    // Control registers
    // --------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            mode_q <= RST_MAIN_MODE_CONTROL[7:0];
            window_q <= RST_STANDBY_TIMER_WINDOW;
            timer_on_q <= 1'b0;
            init_done_q <= 1'b0;
        end
        else
        begin
            init_done_q <= 1'b1;
            if (wr_mode) // [RULE9] [RULE14]
                mode_q <= acc_wdata[7:0];
            if (wr_smc)
            begin
                window_q <= acc_wdata[SMC_WINDOW_LSB +: 4];
                timer_on_q <= acc_wdata[SMC_TIMER_ON];
            end
            else if (!init_done_q)
                timer_on_q <= standby_timer_fuse; // [RULE17]
        end
    end

    // --------------------------------------------------------------------
    // Read mux
    // --------------------------------------------------------------------
    wire [15:0] mode_rd = {8'h00, pll_locked, 1'b0, main_normal,
        mode_q[4:0]}; // [RULE13] [RULE15]
    wire [15:0] smc_rd = {window_q, 1'b0, timer_on_q, 10'h000};

    always_comb
    begin
        unique case (adr)
            ADR_MAIN_EVENT_FLAGS: rdata_next = flags_q;
            ADR_MAIN_MODE_CONTROL: rdata_next = mode_rd;
            ADR_STATE_MACHINE_CONTROL: rdata_next = smc_rd;
            default: rdata_next = 16'h0000; // [RULE25]
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rd_valid_q <= 1'b0;
            rd_data_q <= 16'h0000;
            rd_crc_q <= 8'h00;
        end
        else
        begin
            rd_valid_q <= rd_ok;
            if (rd_ok)
            begin
                rd_data_q <= rdata_next;
                rd_crc_q <= ans_crc; // [RULE23]
            end
        end
    end

    // --------------------------------------------------------------------
    // Outputs and strobes
    // --------------------------------------------------------------------
    wire test_active = mode_q[MODE_TEST_ON] & pgood_test_fuse; // [RULE9]
    wire [7:0] off_w = acc_wdata[REQ_OFF_LSB +: 8];
    wire [6:0] on_w = acc_wdata[6:0] & ~off_w[6:0]; // [RULE24]

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pgood_q <= 1'b0;
            wake_q <= 1'b0;
            slp_q <= 1'b0;
            ext_q <= 1'b0;
            off_q <= 1'b0;
            off_req_q <= 8'h00;
            on_req_q <= 7'h00;
        end
        else
        begin
            pgood_q <= test_active ? ~mode_q[MODE_TEST_LEVEL]
                : sleep_power_good_in; // [RULE10]
            wake_q <= wake_a | wake_b; // [RULE11]
            slp_q <= deep_sleep_fuse & mode_q[MODE_SLP_ON]
                & wake_b; // [RULE12]
            ext_q <= ext_freq_input_req & ~mode_q[MODE_EXT_CLK_DIS]; // [RULE14]
            off_q <= wr_smc & acc_wdata[SMC_ENTER_OFF]; // [RULE16]
            off_req_q <= wr_req ? off_w : 8'h00; // [RULE20] [RULE21]
            on_req_q <= wr_req ? on_w : 7'h00; // [RULE19]
        end
    end

    assign rd_valid = rd_valid_q;
    assign rd_data = rd_data_q;
    assign rd_crc = rd_crc_q;
    assign sleep_power_good_out = pgood_q;
    assign wake_accepted = wake_q;
    assign deep_sleep_state = slp_q;
    assign ext_freq_input = ext_q;
    assign enter_off_state = off_q;
    assign reg_off_req = off_req_q;
    assign reg_on_req = on_req_q;

    // --------------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------------
    property p_comm_err;
        @(posedge clk) disable iff (rst)
        (acc_valid && acc_write && main_sel && wr_crc != acc_crc)
            |=> flags_q[13];
    endproperty
    a_comm_err: assert property (p_comm_err) // [RULE1]
        else $error("comm error flag not set");

    property p_wake;
        @(posedge clk) disable iff (rst)
        (wake_input_a && !mode_q[MODE_WAKE_A_DIS]) |=> flags_q[12] && wake_q;
    endproperty
    a_wake: assert property (p_wake) // [RULE2]
        else $error("wake flag not set");

    property p_wake_block;
        @(posedge clk) disable iff (rst)
        (mode_q[MODE_WAKE_A_DIS] && mode_q[MODE_WAKE_B_DIS]) |=> !wake_q;
    endproperty
    a_wake_block: assert property (p_wake_block) // [RULE11]
        else $error("disabled wake accepted");

    property p_reg_flag;
        @(posedge clk) disable iff (rst)
        ev_regulator[0] |=> flags_q[4];
    endproperty
    a_reg_flag: assert property (p_reg_flag) // [RULE3]
        else $error("regulator flag not set");

    property p_batt;
        @(posedge clk) disable iff (rst)
        (ev_batt_uv7 || ev_batt_uvl) |=> flags_q[1];
    endproperty
    a_batt: assert property (p_batt) // [RULE6]
        else $error("battery flag not set");

    property p_timer;
        @(posedge clk) disable iff (rst)
        timer_expire |=> flags_q[2] && ms_q == 24'd0;
    endproperty
    a_timer: assert property (p_timer) // [RULE7]
        else $error("timer flag not set");

    property p_sticky;
        @(posedge clk) disable iff (rst)
        ##1 (($past(flags_q) & ~flags_q) == 16'h0000);
    endproperty
    a_sticky: assert property (p_sticky) // [RULE8]
        else $error("event flag cleared");

    property p_pgood;
        @(posedge clk) disable iff (rst)
        test_active |=> sleep_power_good_out == !$past(mode_q[MODE_TEST_LEVEL]);
    endproperty
    a_pgood: assert property (p_pgood) // [RULE10]
        else $error("test level not driven");

    property p_sleep;
        @(posedge clk) disable iff (rst)
        !mode_q[MODE_SLP_ON] |=> !deep_sleep_state;
    endproperty
    a_sleep: assert property (p_sleep) // [RULE12]
        else $error("deep sleep without enable");

    property p_off_wins;
        @(posedge clk) disable iff (rst)
        (wr_req && acc_wdata[REQ_OFF_LSB] && acc_wdata[0])
            |=> reg_off_req[0] && !reg_on_req[0];
    endproperty
    a_off_wins: assert property (p_off_wins) // [RULE24]
        else $error("enable beat disable");

    property p_strobe;
        @(posedge clk) disable iff (rst)
        (enter_off_state && !wr_smc) |=> !enter_off_state;
    endproperty
    a_strobe: assert property (p_strobe) // [RULE25] [RULE16]
        else $error("strobe longer than a cycle");

    property p_rd_normal;
        @(posedge clk) disable iff (rst)
        (rd_ok && adr == ADR_MAIN_MODE_CONTROL)
            |=> rd_valid && rd_data[MODE_MAIN_NORMAL] == $past(main_normal);
    endproperty
    a_rd_normal: assert property (p_rd_normal) // [RULE13]
        else $error("normal mode bit wrong");

    c_write_mode: cover property (@(posedge clk) disable iff (rst) wr_mode);
    c_read: cover property (@(posedge clk) disable iff (rst) rd_valid);
    c_expire: cover property (@(posedge clk) disable iff (rst) timer_expire);
    c_bad_crc: cover property (@(posedge clk) disable iff (rst)
        wr_any && !crc_ok);
endmodule
`default_nettype wire

// ---- test/pmr_host.sv ----
// Purpose: Host model that issues decoded register frames.
// Assumes: Frames are driven just after a rising edge, one per call.
// Notes: Released lines show inverted data so stale values cannot match.
`timescale 1ns/1ns
`default_nettype none
module pmr_host
    import pmr_pkg::*;
(
    input wire logic clk,
    output var logic acc_valid,
    output var logic acc_write,
    output var logic [7:0] acc_dev_byte,
    output var logic [7:0] acc_reg_byte,
    output var logic [15:0] acc_wdata,
    output var logic [7:0] acc_crc,
    input wire logic rd_valid,
    input wire logic [15:0] rd_data,
    input wire logic [7:0] rd_crc
);
    // ----------------------------------------------------------------
    // Frame signing and driving
    // ----------------------------------------------------------------
    function automatic logic [7:0] crc8(input logic [31:0] f);
        logic [7:0] c;
        c = CRC_SEED;
        for (int i = 31; i >= 0; i--)
        begin
            c = (c[7] ^ f[i]) ? {c[6:0], 1'b0} ^ CRC_POLY : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    initial
    begin
        acc_valid = 1'b0;
        {acc_write, acc_dev_byte, acc_reg_byte, acc_wdata, acc_crc} = '0;
    end

    task automatic send(input logic wr, input logic [5:0] adr,
        input logic [15:0] d, input logic bad, input logic fs);
        logic [7:0] dev;
        dev = {6'h10, fs, ~wr};
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_write <= wr;
        acc_dev_byte <= dev;
        acc_reg_byte <= {2'b00, adr};
        acc_wdata <= d;
        acc_crc <= crc8({dev, 2'b00, adr, d}) ^ {7'h00, bad};
        @(posedge clk);
        acc_valid <= 1'b0;
        acc_write <= ~wr;
        acc_dev_byte <= ~dev;
        acc_reg_byte <= ~{2'b00, adr};
        acc_wdata <= ~d;
        acc_crc <= ~acc_crc;
    endtask

    task automatic rd(input logic [5:0] adr, output logic [15:0] d,
        output logic ok);
        send(1'b0, adr, 16'h0000, 1'b0, 1'b0);
        #1;
        d = rd_data;
        ok = rd_valid === 1'b1 &&
            rd_crc === crc8({8'h41, 2'b00, adr, rd_data});
    endtask
endmodule
`default_nettype wire

// ---- test/tb_main_control_status_regs.sv ----
// Purpose: Self-checking bench for the main control and status registers.
// Assumes: 25 MHz clock; the host model drives the frame port.
// Notes: The timer runs at four cycles per millisecond here.
`timescale 1ns/1ns
`default_nettype none
module tb_main_control_status_regs
    import pmr_pkg::*;
;
    localparam logic [5:0] A_FLG = ADR_MAIN_EVENT_FLAGS;
    localparam logic [5:0] A_MOD = ADR_MAIN_MODE_CONTROL;
    localparam logic [5:0] A_SMC = ADR_STATE_MACHINE_CONTROL;
    localparam logic [5:0] A_REQ = ADR_REGULATOR_ONOFF_REQUESTS;
    localparam logic [17:0] WA = 18'h02000;
    localparam logic [17:0] WB = 18'h01000;
    logic clk, rst, acc_valid, acc_write, rd_valid;
    logic pg_fuse, ds_fuse, tm_fuse, pg_in, normal, locked, ext_req;
    logic pg_out, wake_acc, deep_st, ext_out, off_out;
    logic [17:0] ev;
    logic [7:0] acc_dev_byte, acc_reg_byte, acc_crc, rd_crc, reg_off_req;
    logic [15:0] acc_wdata, rd_data;
    logic [6:0] reg_on_req;
    int fail_count, samples_checked;

    pmr_host host (.clk, .acc_valid, .acc_write, .acc_dev_byte,
        .acc_reg_byte, .acc_wdata, .acc_crc, .rd_valid, .rd_data, .rd_crc);

    pmr_regs #(.MS_CYCLES_P(4)) uut (.clk, .rst, .acc_valid, .acc_write,
        .acc_dev_byte, .acc_reg_byte, .acc_wdata, .acc_crc,
        .acc_proto_err(ev[14]), .rd_valid, .rd_data, .rd_crc,
        .ev_die_temp(ev[16]), .ev_bias_uvh(ev[15]),
        .wake_input_a(ev[13]), .wake_input_b(ev[12]),
        .ev_regulator(ev[11:4]), .ev_batt_uvl(ev[3]), .ev_batt_uvh(ev[2]),
        .ev_batt_uv7(ev[1]), .ev_thermal_shutdown(ev[0]),
        .ev_hv_linreg(ev[17]),
        .pgood_test_fuse(pg_fuse), .deep_sleep_fuse(ds_fuse),
        .standby_timer_fuse(tm_fuse), .sleep_power_good_in(pg_in),
        .main_normal(normal), .pll_locked(locked),
        .ext_freq_input_req(ext_req), .sleep_power_good_out(pg_out),
        .wake_accepted(wake_acc), .deep_sleep_state(deep_st),
        .ext_freq_input(ext_out), .enter_off_state(off_out),
        .reg_off_req, .reg_on_req);

    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [15:0] got, exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD %0t %s: got %h want %h", $time, what, got, exp);
        end
    endtask

    task automatic rdchk(input logic [5:0] adr, input logic [15:0] exp);
        logic [15:0] d;
        logic ok;
        host.rd(adr, d, ok);
        chk(d, exp, "read data");
        chk({15'h0, ok}, 16'h0001, "read answer");
    endtask

    task automatic wr(input logic [5:0] adr, input logic [15:0] d);
        host.send(1'b1, adr, d, 1'b0, 1'b0);
    endtask

    task automatic do_reset();
        @(posedge clk);
        rst <= 1'b1;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
    endtask

    // Outputs are sampled after each edge so a one-cycle pulse is seen.
    task automatic pulse(input logic [17:0] v, output logic [2:0] hit);
        hit = 3'b000;
        @(posedge clk);
        ev <= v;
        repeat (3)
        begin
            @(posedge clk);
            ev <= 18'h0;
            #1 hit = hit | {deep_st, wake_acc, off_out};
        end
    endtask

    function automatic logic [15:0] fexp(input int j);
        if (j >= 4 && j <= 11) return 16'h0001 << j;
        if (j >= 1 && j <= 3) return 16'h0002;
        if (j == 0) return 16'h0001;
        if (j == 12 || j == 13) return 16'h1000;
        if (j == 17) return 16'h0008;
        return 16'h0001 << (j - 1);
    endfunction

    task automatic wk(input logic [15:0] m, input logic [17:0] v,
        input logic [1:0] e);
        logic [2:0] hit;
        wr(A_MOD, m);
        pulse(v, hit);
        chk({14'h0, hit[2:1]}, {14'h0, e}, "wake outcome");
    endtask

    task automatic pg(input logic [15:0] m, input logic [1:0] e);
        wr(A_MOD, m);
        @(posedge clk);
        #1;
        chk({14'h0, pg_out, ext_out}, {14'h0, e}, "pgood and clock");
    endtask

    task automatic rq(input logic [15:0] d, input logic [15:0] e);
        wr(A_REQ, d);
        #1;
        chk({reg_off_req, 1'b0, reg_on_req}, e, "request strobes");
        @(posedge clk);
        #1;
        chk({reg_off_req, 1'b0, reg_on_req}, 16'h0, "strobe end");
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_refuse();
        rdchk(A_FLG, 16'h0000);
        rdchk(A_MOD, RST_MAIN_MODE_CONTROL);
        rdchk(A_SMC, 16'h0000);
        rdchk(A_REQ, 16'h0000);
        rdchk(6'h3F, 16'h0000);
        host.send(1'b1, A_MOD, 16'h001F, 1'b1, 1'b0);
        rdchk(A_MOD, 16'h0000);
        rdchk(A_FLG, 16'h2000);
        host.send(1'b1, A_MOD, 16'h001F, 1'b0, 1'b1);
        rdchk(A_MOD, 16'h0000);
        $display("test refuse done");
    endtask

    task automatic t_flags();
        logic [2:0] hit;
        for (int j = 17; j >= 0; j--)
        begin
            do_reset();
            pulse(18'h1 << j, hit);
            repeat (3) @(posedge clk);
            rdchk(A_FLG, fexp(j));
        end
        $display("test flags done");
    endtask

    task automatic t_wake();
        wk(16'h0002, WA, 2'b00);
        wk(16'h0002, WB, 2'b01);
        wk(16'h0004, WB, 2'b00);
        wk(16'h0010, WB, 2'b11);
        wk(16'h0010, WA, 2'b01);
        @(posedge clk);
        ds_fuse <= 1'b0;
        wk(16'h0010, WB, 2'b01);
        $display("test wake done");
    endtask

    task automatic t_pg();
        @(posedge clk);
        {pg_in, ext_req, normal, locked} <= 4'hF;
        pg(16'h0000, 2'b11);
        pg(16'h0001, 2'b11);
        pg(16'h0009, 2'b01);
        pg(16'h0008, 2'b11);
        pg(16'h0040, 2'b10);
        wr(A_MOD, 16'h005F);
        rdchk(A_MOD, 16'h00BF);
        @(posedge clk);
        {pg_fuse, normal, locked} <= 3'b000;
        pg(16'h0009, 2'b11);
        rdchk(A_MOD, 16'h0009);
        $display("test pgood done");
    endtask

    task automatic t_req();
        rq(16'h0201, 16'h0201);
        rq(16'hFF7F, 16'hFF00);
        rq(16'h007F, 16'h007F);
        rq(16'h8000, 16'h8000);
        rq(16'h0000, 16'h0000);
        wr(A_SMC, 16'h0001);
        #1;
        chk({15'h0, off_out}, 16'h0001, "enter off");
        @(posedge clk);
        #1;
        chk({15'h0, off_out}, 16'h0000, "enter off end");
        rdchk(A_SMC, 16'h0000);
        rdchk(A_REQ, 16'h0000);
        $display("test requests done");
    endtask

    task automatic t_timer();
        do_reset();
        for (int c = 0; c < 16; c++)
        begin
            wr(A_SMC, {c[3:0], 12'h000});
            rdchk(A_SMC, {c[3:0], 12'h000});
        end
        rdchk(A_FLG, 16'h0000);
        @(posedge clk);
        tm_fuse <= 1'b1;
        do_reset();
        rdchk(A_SMC, 16'h0400);
        repeat (50) @(posedge clk);
        rdchk(A_FLG, 16'h0000);
        repeat (30) @(posedge clk);
        rdchk(A_FLG, 16'h0004);
        @(posedge clk);
        tm_fuse <= 1'b0;
        do_reset();
        wr(A_SMC, 16'h1400);
        repeat (100) @(posedge clk);
        rdchk(A_FLG, 16'h0000);
        repeat (50) @(posedge clk);
        rdchk(A_FLG, 16'h0004);
        $display("test timer done");
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        rst = 1'b1;
        ev = '0;
        {pg_fuse, ds_fuse, tm_fuse, pg_in, normal, locked, ext_req} = 7'h60;
        fail_count = 0;
        samples_checked = 0;
        do_reset();
        t_refuse();
        t_flags();
        t_wake();
        t_pg();
        t_req();
        t_timer();
        results();
    end

    // The scenarios need about 800 cycles; 25 times that means a hang.
    initial
    begin
        repeat (20000) @(posedge clk);
        fail_count++;
        $display("BAD %0t watchdog expired", $time);
        results();
    end
endmodule
`default_nettype wire
